// >>> tsc_pkg.sv
// constants, types and state record of the transparent serial channel
package tsc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_MODE   = 8'h00;
  localparam logic [7:0] OFF_CMD    = 8'h04;
  localparam logic [7:0] OFF_EVENT  = 8'h08;
  localparam logic [7:0] OFF_MASK   = 8'h0c;
  localparam logic [7:0] OFF_DEMAND = 8'h10;
  localparam logic [7:0] OFF_PROTO  = 8'h14;
  localparam logic [7:0] OFF_PTRS   = 8'h18;
  localparam logic [7:0] OFF_MAXLEN = 8'h1c;
  localparam logic [7:0] OFF_CRCP   = 8'h30;
  localparam logic [7:0] OFF_CRCC   = 8'h34;
  // 0x40..0x5f tx descriptors, 0x60..0x7f rx descriptors, 0x80..0xbf data
  localparam logic [1:0] REG_BD     = 2'h1;
  localparam logic [1:0] REG_DATA   = 2'h2;
  // general mode bits
  localparam int M_TXEN = 0;
  localparam int M_RXEN = 1;
  localparam int M_RFW  = 2;
  localparam int M_SYNC_LENGTH = 3;
  localparam int M_CDP  = 5;
  localparam int M_CTS_PULSE_SELECT = 6;
  // event bits
  localparam int EV_RX  = 0;
  localparam int EV_TX  = 1;
  localparam int EV_BSY = 2;
  localparam int EV_TXE = 4;
  localparam int EV_GRA = 7;
  // descriptor status bits
  localparam int BD_OWN = 15;
  localparam int BD_W   = 13;
  localparam int BD_I   = 12;
  localparam int BD_L   = 11;
  localparam int BD_F   = 10;
  localparam int BD_CM  = 9;
  localparam int BD_CR  = 2;
  localparam int BD_OV  = 1;
  localparam int BD_CD  = 0;
  localparam int BD_UN  = 1;
  localparam int BD_CT  = 0;
  // commands
  localparam logic [3:0] CMD_INIT_ALL = 4'h0;
  localparam logic [3:0] CMD_INIT_RX  = 4'h1;
  localparam logic [3:0] CMD_INIT_TX  = 4'h2;
  localparam logic [3:0] CMD_HUNT     = 4'h3;
  localparam logic [3:0] CMD_STOP     = 4'h4;
  localparam logic [3:0] CMD_GSTOP    = 4'h5;
  localparam logic [3:0] CMD_RESTART  = 4'h6;
  localparam logic [3:0] CMD_CLOSE_RX = 4'h7;
  // timing and sizes
  localparam logic [5:0]  POLL_LAST  = 6'h3f;
  localparam logic [15:0] CRC_POLY   = 16'h8408;
  localparam logic [15:0] MAXLEN_RST = 16'h0010;
  localparam logic [2:0]  RFW_WIDE   = 3'h4;

  typedef enum logic [1:0] {
    TX_POLL = 2'b00,
    TX_SYNC = 2'b01,
    TX_SEND = 2'b10,
    TX_STOP = 2'b11
  } tsc_tx_type;

  typedef enum logic [1:0] {
    RX_HUNT  = 2'b00,
    RX_RECV  = 2'b01,
    RX_FLUSH = 2'b10
  } tsc_rx_type;

  typedef struct packed {
    logic [6:0]        mode;
    logic [15:0]       mask;
    logic [15:0]       event_bits;
    logic              transmit_on_demand;
    logic [31:0]       proto;
    logic [31:0]       crcp;
    logic [31:0]       crcc;
    logic [15:0]       maxlen;
    logic [7:0][31:0]  txbd;
    logic [7:0][31:0]  rxbd;
    logic [15:0][31:0] data;
    logic [31:0]       rdata;
    logic              irq;
    logic [7:0]        sy;
    logic              lclk;
    tsc_tx_type        tst;
    logic [1:0]        tptr;
    logic [5:0]        pcnt;
    logic [15:0]       tbyte;
    logic [2:0]        tbit;
    logic [7:0]        tsh;
    logic              gstop;
    logic              stop_req;
    logic              txd;
    logic              rts;
    tsc_rx_type        rst;
    logic [1:0]        rptr;
    logic [7:0]        rsh;
    logic [2:0]        rbit;
    logic [15:0]       rcnt;
    logic [3:0][7:0]   fifo;
    logic [2:0]        fcnt;
    logic              drain;
    logic [15:0]       rcrc;
    logic [15:0]       rflags;
    logic              rfirst;
    logic              rhunt;
  } tsc_state_type;
endpackage

// >>> tsc_channel.sv
// transparent serial channel: descriptors, commands, line transmitter and receiver
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Contract
// - after enable, poll first tx descriptor every 64 clocks, at once on demand
// - stop during frame aborts within 8 bits, pointer kept, idles sent
// - graceful stop halts at frame end with pointer advanced, or at once when polling; sets event
// - after graceful stop, resume needs ready descriptor and restart command
// - restart resumes from current pointer after any stop or tx error
// - init tx resets all transmit parameters
// - init rx resets receive parameters; combined command resets both
// - after enable receiver hunts and uses first rx descriptor
// - enter hunt aborts frame, closes buffer, waits sync, next descriptor
// - close rx command closes active buffer, ignored when not receiving
// - underrun closes buffer without flag, raises tx error, waits restart
// - underrun after non-last buffer raises tx error, plus tx event if interrupt bit set
// - lost clear-to-send closes buffer with flag, tx error, waits restart
// - memory transfer and crc start after 8 or 32 bits, per width setting
// - overrun overwrites last byte, closes with flag, rx event, hunt
// - carrier loss has top priority, closes, flags a partial byte, rx event, hunt
// - error, full buffer, hunt or close command closes buffer and moves on
// - rx descriptor status layout, length word and buffer pointer
// - protocol mode register is kept but ignored
// - receive crc compared with check constant register
// - request-to-send marks frame envelope for peer carrier detect
// - zero sync length: clear-to-send starts tx, carrier detect starts rx
// - pulse setting picks single assertion or whole-frame envelope
// - event bits clear on written one, request held while unmasked bit set
//////////////////////////////////////////////////////////////////////////////
module tsc_channel (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // register port
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [31:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [31:0] REG_RDATA_O,
  output logic             IRQ_O,
  // serial line
  input  wire logic        LCLK_I,
  input  wire logic        RXD_I,
  input  wire logic        CD_N_I,
  input  wire logic        CTS_N_I,
  output logic             TXD_O,
  output logic             RTS_N_O
);
  tsc_pkg::tsc_state_type s;
  tsc_pkg::tsc_state_type n;
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ tsc_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
  function automatic logic [7:0] rd_byte(input logic [15:0][31:0] m, input logic [5:0] a);
    return m[a[5:2]][{a[1:0], 3'h0} +: 8];
  endfunction
  assign REG_RDATA_O = s.rdata;
  assign IRQ_O       = s.irq;
  assign TXD_O       = s.txd;
  assign RTS_N_O     = ~s.rts;
  always_comb begin
    logic [15:0] ev_set;
    logic        lrise;
    logic        lfall;
    logic        cd_on;
    logic        cts_on;
    logic        ext_sync;
    logic [2:0]  ti;
    logic [2:0]  ri;
    logic [1:0]  np;
    logic [5:0]  a;
    logic [2:0]  thr;
    n        = s;
    ev_set   = 16'h0000;
    // two-flop pin sync: [7:4] first stage, [3:0] cts, cd, rxd, clk
    n.sy     = {CTS_N_I, CD_N_I, RXD_I, LCLK_I, s.sy[7:4]};
    n.lclk   = s.sy[0];
    lrise    = s.sy[0] & ~s.lclk;
    lfall    = ~s.sy[0] & s.lclk;
    cd_on    = ~s.sy[2];
    cts_on   = ~s.sy[3];
    ext_sync = s.mode[tsc_pkg::M_SYNC_LENGTH +: 2] == 2'h0;
    ti       = {s.tptr, 1'b0};
    ri       = {s.rptr, 1'b0};
    np       = s.txbd[ti][tsc_pkg::BD_W] ? 2'h0 : s.tptr + 2'h1;
    thr      = s.mode[tsc_pkg::M_RFW] ? tsc_pkg::RFW_WIDE : 3'h1;
    a        = 6'h00;
    ////////////////////////////////////////////////////////////////////////////
    // transmitter
    // envelope drops with idle
    if (lfall && s.tst != tsc_pkg::TX_SEND) begin
      n.txd = 1'b1;
      n.rts = 1'b0;
    end
    unique case (s.tst)
      tsc_pkg::TX_POLL: begin
        if (s.gstop) begin
          n.gstop = 1'b0;
          n.tst   = tsc_pkg::TX_STOP;
          ev_set[tsc_pkg::EV_GRA] = 1'b1;
        end else if (s.mode[tsc_pkg::M_TXEN]) begin
          n.pcnt = s.pcnt + 6'h1;
          if (s.transmit_on_demand || s.pcnt == tsc_pkg::POLL_LAST) begin
            n.pcnt = 6'h00;
            n.transmit_on_demand  = 1'b0;
            if (s.txbd[ti][tsc_pkg::BD_OWN]) begin
              n.tst = tsc_pkg::TX_SYNC;
            end
          end
        end
      end
      tsc_pkg::TX_SYNC: begin
        if ((ext_sync ? cts_on : 1'b1) && lfall) begin
          n.tst   = tsc_pkg::TX_SEND;
          n.tbyte = 16'h0000;
          n.tbit  = 3'h1;
          n.tsh   = rd_byte(s.data, s.txbd[ti + 3'h1][5:0]);
          n.txd   = n.tsh[0];
          n.tsh   = n.tsh >> 1;
          n.rts   = 1'b1;
        end
      end
      tsc_pkg::TX_SEND: begin
        if (!s.mode[tsc_pkg::M_CTS_PULSE_SELECT] && ext_sync && !cts_on) begin
          n.txbd[ti][tsc_pkg::BD_OWN] = 1'b0;
          n.txbd[ti][tsc_pkg::BD_CT]  = 1'b1;
          ev_set[tsc_pkg::EV_TXE]     = 1'b1;
          n.tst = tsc_pkg::TX_STOP;
          n.rts = 1'b0;
          n.txd = 1'b1;
        end else if (lfall) begin
          n.txd  = s.tsh[0];
          n.tsh  = s.tsh >> 1;
          n.tbit = s.tbit + 3'h1;
          if (s.tbit == 3'h7) begin
            if (s.stop_req) begin
              n.stop_req = 1'b0;
              n.tst      = tsc_pkg::TX_STOP;
            end else if (s.tbyte + 16'h1 >= s.txbd[ti][31:16]) begin
              n.txbd[ti][tsc_pkg::BD_OWN] = s.txbd[ti][tsc_pkg::BD_CM];
              ev_set[tsc_pkg::EV_TX] = s.txbd[ti][tsc_pkg::BD_I];
              n.tptr = np;
              if (s.txbd[ti][tsc_pkg::BD_L]) begin
                n.gstop = 1'b0;
                n.tst   = s.gstop ? tsc_pkg::TX_STOP : tsc_pkg::TX_POLL;
                ev_set[tsc_pkg::EV_GRA] = s.gstop;
              end else if (s.txbd[{np, 1'b0}][tsc_pkg::BD_OWN]) begin
                n.tbyte = 16'h0000;
                n.tsh   = rd_byte(s.data, s.txbd[{np, 1'b1}][5:0]);
              end else begin
                ev_set[tsc_pkg::EV_TXE] = 1'b1;
                n.tst = tsc_pkg::TX_STOP;
              end
            end else begin
              n.tbyte = s.tbyte + 16'h1;
              a       = s.txbd[ti + 3'h1][5:0] + s.tbyte[5:0] + 6'h1;
              n.tsh   = rd_byte(s.data, a);
            end
          end
        end
      end
      tsc_pkg::TX_STOP: ;
    endcase
    ////////////////////////////////////////////////////////////////////////////
    // receiver
    if (s.fcnt >= thr) begin
      n.drain = 1'b1;
    end
    unique case (s.rst)
      tsc_pkg::RX_HUNT: begin
        if (s.mode[tsc_pkg::M_RXEN] && (ext_sync ? cd_on : 1'b1)) begin
          if (s.rxbd[ri][tsc_pkg::BD_OWN]) begin
            n.rst    = tsc_pkg::RX_RECV;
            n.rcnt   = 16'h0000;
            n.rbit   = 3'h0;
            n.rfirst = 1'b1;
            n.rflags = 16'h0000;
            n.rcrc   = s.crcp[15:0];
          end else begin
            ev_set[tsc_pkg::EV_BSY] = 1'b1;
          end
        end
      end
      tsc_pkg::RX_RECV: begin
        if (!s.mode[tsc_pkg::M_CDP] && ext_sync && !cd_on) begin
          n.rst   = tsc_pkg::RX_FLUSH;
          n.rhunt = 1'b1;
          n.rflags[tsc_pkg::BD_L] = 1'b1;
          if (s.rbit != 3'h0) begin
            n.rflags[tsc_pkg::BD_CD] = 1'b1;
          end
        end else if (s.rcnt >= s.maxlen) begin
          n.rst   = tsc_pkg::RX_FLUSH;
          n.rhunt = 1'b0;
        end else if (lrise) begin
          n.rsh  = {s.sy[1], s.rsh[7:1]};
          n.rbit = s.rbit + 3'h1;
          if (s.rbit == 3'h7) begin
            if (s.fcnt == 3'h4 || (!s.mode[tsc_pkg::M_RFW] && s.fcnt != 3'h0)) begin
              n.fifo[s.fcnt - 3'h1] = {s.sy[1], s.rsh[7:1]};
              n.rflags[tsc_pkg::BD_OV] = 1'b1;
              n.rflags[tsc_pkg::BD_L]  = 1'b1;
              n.rst   = tsc_pkg::RX_FLUSH;
              n.rhunt = 1'b1;
            end else begin
              n.fifo[s.fcnt[1:0]] = {s.sy[1], s.rsh[7:1]};
              n.fcnt = s.fcnt + 3'h1;
            end
          end
        end
      end
      tsc_pkg::RX_FLUSH: begin
        if (s.fcnt == 3'h0 || s.rcnt >= s.maxlen) begin
          n.rxbd[ri][15:0]  = {s.rxbd[ri][tsc_pkg::BD_CM] && s.rflags[2:0] == 3'h0,
                               s.rxbd[ri][14:12], s.rflags[tsc_pkg::BD_L], s.rfirst,
                               s.rxbd[ri][9:8], 5'h00, s.rflags[2:0]};
          // crc check at clean frame end
          if (s.rflags[tsc_pkg::BD_L] && s.rflags[2:0] == 3'h0 && s.rcrc != s.crcc[15:0]) begin
            n.rxbd[ri][tsc_pkg::BD_CR] = 1'b1;
          end
          n.rxbd[ri][31:16] = s.rcnt;
          ev_set[tsc_pkg::EV_RX] = s.rxbd[ri][tsc_pkg::BD_I];
          n.rptr   = s.rxbd[ri][tsc_pkg::BD_W] ? 2'h0 : s.rptr + 2'h1;
          n.rcnt   = 16'h0000;
          n.rfirst = 1'b0;
          n.rflags = 16'h0000;
          if (s.rhunt) begin
            n.rst  = tsc_pkg::RX_HUNT;
            n.fcnt = 3'h0;
          end else begin
            n.rst  = tsc_pkg::RX_RECV;
          end
        end
      end
      default: begin
        n.rst = tsc_pkg::RX_HUNT;
      end
    endcase
    if (s.fcnt != 3'h0 && (s.drain || s.rst == tsc_pkg::RX_FLUSH) && s.rcnt < s.maxlen
        && s.rst != tsc_pkg::RX_HUNT) begin
      a = s.rxbd[ri + 3'h1][5:0] + s.rcnt[5:0];
      n.data[a[5:2]][{a[1:0], 3'h0} +: 8] = s.fifo[0];
      n.rcrc = crc_step(s.rcrc, s.fifo[0]);
      n.rcnt = s.rcnt + 16'h1;
      n.fifo = {8'h00, s.fifo[3:1]};
      n.fcnt = n.fcnt - 3'h1;
      if (s.fcnt == 3'h1) begin
        n.drain = 1'b0;
      end
    end
    ////////////////////////////////////////////////////////////////////////////
    // register port
    if (REG_WR_I) begin
      if (REG_ADDR_I[7:6] == tsc_pkg::REG_BD) begin
        if (REG_ADDR_I[5]) begin
          n.rxbd[REG_ADDR_I[4:2]] = REG_WDATA_I;
        end else begin
          n.txbd[REG_ADDR_I[4:2]] = REG_WDATA_I;
        end
      end else if (REG_ADDR_I[7:6] == tsc_pkg::REG_DATA) begin
        n.data[REG_ADDR_I[5:2]] = REG_WDATA_I;
      end else begin
        unique case (REG_ADDR_I)
          tsc_pkg::OFF_MODE:   n.mode   = REG_WDATA_I[6:0];
          tsc_pkg::OFF_MASK:   n.mask   = REG_WDATA_I[15:0];
          tsc_pkg::OFF_DEMAND: n.transmit_on_demand    = REG_WDATA_I[0];
          tsc_pkg::OFF_PROTO:  n.proto  = REG_WDATA_I;
          tsc_pkg::OFF_MAXLEN: n.maxlen = REG_WDATA_I[15:0];
          tsc_pkg::OFF_CRCP:   n.crcp   = REG_WDATA_I;
          tsc_pkg::OFF_CRCC:   n.crcc   = REG_WDATA_I;
          default: ;
        endcase
      end
    end
    n.event_bits = (REG_WR_I && REG_ADDR_I == tsc_pkg::OFF_EVENT)
                   ? (s.event_bits & ~REG_WDATA_I[15:0]) : s.event_bits;
    n.event_bits = n.event_bits | ev_set;
    n.irq = |(s.event_bits & s.mask);
    ////////////////////////////////////////////////////////////////////////////
    // commands
    if (REG_WR_I && REG_ADDR_I == tsc_pkg::OFF_CMD) begin
      unique case (REG_WDATA_I[3:0])
        tsc_pkg::CMD_STOP: begin
          if (s.tst == tsc_pkg::TX_SEND) begin
            n.stop_req = 1'b1;
          end else begin
            n.tst = tsc_pkg::TX_STOP;
          end
        end
        tsc_pkg::CMD_GSTOP: n.gstop = s.tst != tsc_pkg::TX_STOP;
        tsc_pkg::CMD_RESTART: begin
          if (s.tst == tsc_pkg::TX_STOP) begin
            n.tst  = tsc_pkg::TX_POLL;
            n.pcnt = 6'h00;
          end
        end
        tsc_pkg::CMD_HUNT, tsc_pkg::CMD_CLOSE_RX: begin
          if (s.rst == tsc_pkg::RX_RECV) begin
            n.rst   = tsc_pkg::RX_FLUSH;
            n.rhunt = REG_WDATA_I[3:0] == tsc_pkg::CMD_HUNT;
          end
        end
        default: begin
        end
      endcase
      if (REG_WDATA_I[3:0] == tsc_pkg::CMD_INIT_TX || REG_WDATA_I[3:0] == tsc_pkg::CMD_INIT_ALL) begin
        n.tst      = tsc_pkg::TX_POLL;
        n.tptr     = 2'h0;
        n.pcnt     = 6'h00;
        n.transmit_on_demand      = 1'b0;
        n.gstop    = 1'b0;
        n.stop_req = 1'b0;
        n.rts      = 1'b0;
        n.txd      = 1'b1;
      end
      if (REG_WDATA_I[3:0] == tsc_pkg::CMD_INIT_RX || REG_WDATA_I[3:0] == tsc_pkg::CMD_INIT_ALL) begin
        n.rst    = tsc_pkg::RX_HUNT;
        n.rptr   = 2'h0;
        n.fcnt   = 3'h0;
        n.drain  = 1'b0;
        n.rcnt   = 16'h0000;
        n.rflags = 16'h0000;
        n.maxlen = tsc_pkg::MAXLEN_RST;
      end
    end
    // read data valid the cycle after the strobe only
    n.rdata = 32'h0000_0000;
    if (REG_RD_I) begin
      if (REG_ADDR_I[7:6] == tsc_pkg::REG_BD) begin
        n.rdata = REG_ADDR_I[5] ? s.rxbd[REG_ADDR_I[4:2]] : s.txbd[REG_ADDR_I[4:2]];
      end else if (REG_ADDR_I[7:6] == tsc_pkg::REG_DATA) begin
        n.rdata = s.data[REG_ADDR_I[5:2]];
      end else begin
        unique case (REG_ADDR_I)
          tsc_pkg::OFF_MODE:   n.rdata = {25'h0, s.mode};
          tsc_pkg::OFF_EVENT:  n.rdata = {16'h0, s.event_bits};
          tsc_pkg::OFF_MASK:   n.rdata = {16'h0, s.mask};
          tsc_pkg::OFF_DEMAND: n.rdata = {31'h0, s.transmit_on_demand};
          tsc_pkg::OFF_PROTO:  n.rdata = s.proto;
          tsc_pkg::OFF_PTRS:   n.rdata = {20'h0, s.rst, s.rptr, 2'h0, s.tst, 2'h0, s.tptr};
          tsc_pkg::OFF_MAXLEN: n.rdata = {16'h0, s.maxlen};
          tsc_pkg::OFF_CRCP:   n.rdata = s.crcp;
          tsc_pkg::OFF_CRCC:   n.rdata = s.crcc;
          default:             n.rdata = 32'h0000_0000;
        endcase
      end
    end
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s        <= '0;
      s.txd    <= 1'b1;
      s.sy     <= 8'hff;
      s.lclk   <= 1'b1;
      s.maxlen <= tsc_pkg::MAXLEN_RST;
    end else begin
      s <= n;
    end
  end

endmodule

// >>> tsc_chk_sva.sv
// port assertions of the transparent serial channel
`timescale 1ns/1ps
module tsc_chk (
  // clock and reset
  input wire logic        CLK_I,
  input wire logic        RST_I,
  // register port
  input wire logic [7:0]  REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic        REG_WR_I,
  input wire logic        REG_RD_I,
  input wire logic [31:0] REG_RDATA_O,
  input wire logic        IRQ_O,
  // serial line
  input wire logic        LCLK_I,
  input wire logic        RXD_I,
  input wire logic        CD_N_I,
  input wire logic        CTS_N_I,
  input wire logic        TXD_O,
  input wire logic        RTS_N_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  sequence hole_rd_s;
    REG_RD_I && REG_ADDR_I inside {[8'h20:8'h2c], [8'hc0:8'hff]};
  endsequence
  sequence mask_off_s;
    REG_WR_I && REG_ADDR_I == tsc_pkg::OFF_MASK && REG_WDATA_I == 32'h0;
  endsequence
  sequence bit_edge_s;
    $changed(TXD_O) && !RTS_N_O && !$past(RTS_N_O);
  endsequence
  reset_out_a: assert property (disable iff (1'b0)
    RST_I |=> TXD_O && RTS_N_O && !IRQ_O && REG_RDATA_O == 32'h0) else $error("outputs not idle after reset");
  rdata_idle_a: assert property (!REG_RD_I |=> REG_RDATA_O == 32'h0) else $error("read data without read");
  hole_read_a: assert property (hole_rd_s |=> REG_RDATA_O == 32'h0) else $error("unmapped read not zero");
  idle_line_a: assert property (RTS_N_O && $past(RTS_N_O) |-> TXD_O) else $error("no idle outside frame");
  bit_hold_a: assert property (bit_edge_s |=> $stable(TXD_O) [*6]) else $error("bit shorter than link period");
  frame_min_a: assert property ($fell(RTS_N_O) |=> !RTS_N_O [*8]) else $error("frame envelope too short");
  cts_start_a: assert property ($fell(RTS_N_O) |-> !$past(CTS_N_I)) else $error("frame without clear to send");
  irq_mask_a: assert property (mask_off_s |-> ##2 !IRQ_O) else $error("request kept with all masked");
endmodule

// >>> tsc_peer.sv
// far-end serial peer: captures sent bytes, sends framed bits
`timescale 1ns/1ps
module tsc_peer (
  // link side
  input  wire logic lclk_i,
  input  wire logic txd_i,
  input  wire logic rts_n_i,
  output logic      rxd_o,
  output logic      cd_n_o,
  output logic      cts_n_o
);
  logic [7:0] got;
  initial begin
    rxd_o   = 1'b1;
    cd_n_o  = 1'b1;
    cts_n_o = 1'b1;
    got     = 8'h0;
  end
  always @(posedge lclk_i) begin
    if (!rts_n_i) got <= {txd_i, got[7:1]};
  end
  task automatic send(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge lclk_i);
      cd_n_o = 1'b0;
      rxd_o  = b[i];
    end
    @(negedge lclk_i);
    cd_n_o = 1'b1;
    rxd_o  = ~rxd_o;
  endtask
endmodule

// >>> testbench.sv
// self-checking bench of the transparent serial channel
`timescale 1ns/1ps
module testbench;
  logic        clk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        irq;
  logic        lclk;
  logic        rxd;
  logic        cd_n;
  logic        cts_n;
  logic        txd;
  logic        rts_n;
  int          errors;
  int          tests_run;
  tsc_channel u_tsc_channel (.CLK_I(clk), .RST_I(rst), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
    .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .IRQ_O(irq), .LCLK_I(lclk),
    .RXD_I(rxd), .CD_N_I(cd_n), .CTS_N_I(cts_n), .TXD_O(txd), .RTS_N_O(rts_n));
  tsc_peer u_tsc_peer (.lclk_i(lclk), .txd_i(txd), .rts_n_i(rts_n), .rxd_o(rxd), .cd_n_o(cd_n), .cts_n_o(cts_n));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #3;
    forever #40 lclk = ~lclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), e, reg_rdata & m);
    @(posedge clk);
  endtask
  task automatic rts_wait(input logic lvl, input int n);
    int i;
    for (i = 0; i < n && rts_n !== lvl; i++) @(posedge clk);
    chk("rts", {31'h0, lvl}, {31'h0, rts_n});
  endtask
  task automatic t_regs;
    rd(tsc_pkg::OFF_MAXLEN, 32'hffff, 32'h10);
    rd(tsc_pkg::OFF_PTRS, 32'hfff, 32'h0);
    wr(tsc_pkg::OFF_CRCP, 32'h0000ffff);
    wr(tsc_pkg::OFF_CRCC, 32'h0000f0b8);
    wr(tsc_pkg::OFF_PROTO, 32'h5a5a0001);
    wr(8'h20, 32'hffffffff);
    rd(tsc_pkg::OFF_CRCP, 32'hffffffff, 32'h0000ffff);
    rd(tsc_pkg::OFF_CRCC, 32'hffffffff, 32'h0000f0b8);
    rd(tsc_pkg::OFF_PROTO, 32'hffffffff, 32'h5a5a0001);
    rd(8'h20, 32'hffffffff, 32'h0);
    $display("regs done");
  endtask
  task automatic t_tx;
    wr(8'h80, 32'h00005aa5);
    wr(8'h44, 32'h0);
    wr(8'h4c, 32'h1);
    wr(tsc_pkg::OFF_MODE, 32'h1);
    repeat (70) @(posedge clk);
    wr(8'h40, 32'h00019800);
    wr(tsc_pkg::OFF_DEMAND, 32'h1);
    repeat (100) @(posedge clk);
    rts_wait(1'b1, 1);
    u_tsc_peer.cts_n_o <= 1'b0;
    rts_wait(1'b0, 80);
    rts_wait(1'b1, 1500);
    chk("byte", 32'ha5, {24'h0, u_tsc_peer.got});
    rd(8'h40, 32'hffffffff, 32'h00011800);
    rd(tsc_pkg::OFF_PTRS, 32'h3, 32'h1);
    rd(tsc_pkg::OFF_EVENT, 32'h2, 32'h2);
    $display("tx done");
  endtask
  task automatic t_gstop;
    wr(tsc_pkg::OFF_MASK, 32'h80);
    wr(tsc_pkg::OFF_CMD, {28'h0, tsc_pkg::CMD_GSTOP});
    repeat (4) @(posedge clk);
    rd(tsc_pkg::OFF_EVENT, 32'h80, 32'h80);
    chk("irq", 32'h1, {31'h0, irq});
    wr(tsc_pkg::OFF_EVENT, 32'h0);
    rd(tsc_pkg::OFF_EVENT, 32'h80, 32'h80);
    wr(tsc_pkg::OFF_EVENT, 32'h80);
    rd(tsc_pkg::OFF_EVENT, 32'h80, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h48, 32'h00018800);
    wr(tsc_pkg::OFF_DEMAND, 32'h1);
    repeat (100) @(posedge clk);
    rts_wait(1'b1, 1);
    wr(tsc_pkg::OFF_CMD, {28'h0, tsc_pkg::CMD_RESTART});
    rts_wait(1'b0, 100);
    rts_wait(1'b1, 1500);
    chk("byte", 32'h5a, {24'h0, u_tsc_peer.got});
    rd(tsc_pkg::OFF_PTRS, 32'h3, 32'h2);
    wr(tsc_pkg::OFF_CMD, {28'h0, tsc_pkg::CMD_STOP});
    rd(tsc_pkg::OFF_PTRS, 32'h30, 32'h30);
    wr(tsc_pkg::OFF_CMD, {28'h0, tsc_pkg::CMD_RESTART});
    rd(tsc_pkg::OFF_PTRS, 32'h33, 32'h2);
    wr(tsc_pkg::OFF_MASK, 32'h0);
    $display("graceful stop done");
  endtask
  task automatic t_rx;
    wr(8'h60, 32'h00009000);
    wr(8'h64, 32'h20);
    wr(8'h68, 32'h00008000);
    wr(8'h6c, 32'h24);
    wr(tsc_pkg::OFF_MODE, 32'h3);
    u_tsc_peer.send(8'h3c, 8);
    repeat (30) @(posedge clk);
    rd(8'h60, 32'hfffffffb, 32'h00011c00);
    rd(8'ha0, 32'hff, 32'h3c);
    rd(tsc_pkg::OFF_EVENT, 32'h1, 32'h1);
    u_tsc_peer.send(8'h0f, 4);
    repeat (30) @(posedge clk);
    rd(8'h68, 32'h8801, 32'h0801);
    rd(tsc_pkg::OFF_PTRS, 32'h300, 32'h200);
    wr(tsc_pkg::OFF_CMD, {28'h0, tsc_pkg::CMD_CLOSE_RX});
    rd(tsc_pkg::OFF_PTRS, 32'h300, 32'h200);
    wr(tsc_pkg::OFF_CMD, {28'h0, tsc_pkg::CMD_INIT_ALL});
    rd(tsc_pkg::OFF_PTRS, 32'h33, 32'h0);
    rd(tsc_pkg::OFF_PTRS, 32'hf00, 32'h0);
    $display("rx done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    rst       = 1'b1;
    reg_addr  = 8'h0;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    errors    = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_tx;
    t_gstop;
    t_rx;
    results;
  end
  initial begin
    #200000;
    errors++;
    results;
  end
endmodule
bind tsc_channel tsc_chk u_tsc_chk (.CLK_I(CLK_I), .RST_I(RST_I), .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
  .IRQ_O(IRQ_O), .LCLK_I(LCLK_I), .RXD_I(RXD_I), .CD_N_I(CD_N_I), .CTS_N_I(CTS_N_I),
  .TXD_O(TXD_O), .RTS_N_O(RTS_N_O));
